// ===== src/periodic_wakeup_counter_pkg.sv
package periodic_wakeup_counter_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFF_STATUS_CONTROL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_COUNTER_VALUE = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_MATCH_LIMIT = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_GATE = 12'h00c;

  // status/control and clock gate field positions
  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned SRC_HI = 6;
  localparam int unsigned SRC_LO = 5;
  localparam int unsigned IE_BIT = 4;
  localparam int unsigned PS_HI = 3;
  localparam int unsigned PS_LO = 0;
  localparam int unsigned GATE_BIT = 0;

  // reset values
  localparam logic [1:0] SRC_RST = 2'h0;
  localparam logic [3:0] PS_RST = 4'h0;
  localparam logic [7:0] LIMIT_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic GATE_RST = 1'h1;

  // source select codes; 1x is the internal reference clock
  localparam logic [1:0] SRC_LPO = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam int unsigned SRC_IRC_BIT = 1;

  // prescaler
  localparam int unsigned DIV_W = 18;
  localparam logic [3:0] PS_OFF = 4'h0;

  // clock source inputs, one bit each
  localparam int unsigned NUM_SRC = 3;

  typedef struct packed {
    logic flag;
    logic [1:0] src;
    logic ie;
    logic [3:0] ps;
  } ctrl_s;

  typedef struct packed {
    logic wait_mode;
    logic light_stop_mode;
    logic deepest_stop_mode;
    logic debug_halt;
  } power_mode_s;

  localparam ctrl_s CTRL_RST = '{flag: 1'h0, src: SRC_RST, ie: 1'h0, ps: PS_RST};

endpackage : periodic_wakeup_counter_pkg

// ===== src/level_sync.sv
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : level_sync
`default_nettype wire

// ===== src/wakeup_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module wakeup_prescaler (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic src_tick,
  input wire logic clear,
  input wire logic hold,
  input wire logic [3:0] code,
  input wire logic binary_sel,
  // output
  output logic terminal_tick
);
  import periodic_wakeup_counter_pkg::*;

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic term_q;
  logic term_d;
  logic [DIV_W-1:0] ratio;

  function automatic logic [DIV_W-1:0] divide_by(input logic [3:0] c, input logic sel);
    logic [DIV_W-1:0] r;
    r = 18'h00001;
    if (!sel) begin
      unique case (c)
        4'h1: r = 18'h00008;
        4'h2: r = 18'h00020;
        4'h3: r = 18'h00040;
        4'h4: r = 18'h00080;
        4'h5: r = 18'h00100;
        4'h6: r = 18'h00200;
        4'h7: r = 18'h00400;
        4'h8: r = 18'h00001;
        4'h9: r = 18'h00002;
        4'ha: r = 18'h00004;
        4'hb: r = 18'h0000a;
        4'hc: r = 18'h00010;
        4'hd: r = 18'h00064;
        4'he: r = 18'h001f4;
        4'hf: r = 18'h003e8;
        default: r = 18'h00001;
      endcase
    end else begin
      unique case (c)
        4'h1: r = 18'h00400;
        4'h2: r = 18'h00800;
        4'h3: r = 18'h01000;
        4'h4: r = 18'h02000;
        4'h5: r = 18'h04000;
        4'h6: r = 18'h08000;
        4'h7: r = 18'h10000;
        4'h8: r = 18'h003e8;
        4'h9: r = 18'h007d0;
        4'ha: r = 18'h01388;
        4'hb: r = 18'h02710;
        4'hc: r = 18'h04e20;
        4'hd: r = 18'h0c350;
        4'he: r = 18'h186a0;
        4'hf: r = 18'h30d40;
        default: r = 18'h00001;
      endcase
    end
    return r;
  endfunction : divide_by

  assign ratio = divide_by(code, binary_sel);

  always_comb begin
    cnt_d = cnt_q;
    term_d = 1'b0;
    if (clear) begin
      cnt_d = '0;
    end else if (code != PS_OFF && !hold && src_tick) begin
      if (cnt_q >= ratio - 18'h00001) begin
        cnt_d = '0;
        term_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 18'h00001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      term_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      term_q <= term_d;
    end
  end

  assign terminal_tick = term_q;

endmodule : wakeup_prescaler
`default_nettype wire

// ===== src/periodic_wakeup_counter.sv
// Contract
// - deepest stop: internal reference source is blocked
// - stop wakeup leaves all registers intact
// - bus clock gate resets set, clear blocks
// - counting and interrupt continue in wait
// - counting and wakeup continue in stops
// - debug halt freezes count and prescaler
// - flag sets on match, write-one clears
// - source select chooses prescaler input, resets 00
// - new source select clears prescaler and count
// - interrupt enable gates flag onto request
// - prescaler select zero stops counting
// - new prescaler select clears prescaler and count
// - decimal-style divide table with bit0 clear
// - binary-style divide table with bit0 set
// - eight-bit up-counter against eight-bit limit
// - match wraps count to zero, sets flag
// - any limit write clears prescaler and count
// - count register ignores writes
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module periodic_wakeup_counter (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [periodic_wakeup_counter_pkg::ADDR_W-1:0] paddr,
  input wire logic [periodic_wakeup_counter_pkg::DATA_W-1:0] pwdata,
  output logic [periodic_wakeup_counter_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // counter clock sources, asynchronous to pclk
  input wire logic low_power_osc_clock,
  input wire logic external_ref_clock,
  input wire logic internal_ref_clock,
  // processor power and debug state
  input wire periodic_wakeup_counter_pkg::power_mode_s power_mode,
  // requests to the processor
  output logic match_irq,
  output logic wakeup_req
);
  import periodic_wakeup_counter_pkg::*;

  // register state
  ctrl_s ctrl_q;
  ctrl_s ctrl_d;
  logic [7:0] limit_q;
  logic [7:0] limit_d;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic gate_q;
  logic gate_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // source edge detection
  logic [NUM_SRC-1:0] src_sync;
  logic [NUM_SRC-1:0] src_prev_q;
  logic [NUM_SRC-1:0] src_rise;
  logic src_tick;
  logic term_tick;

  // bus decode
  logic setup_phase;
  logic access_phase;
  logic hit_ctrl;
  logic hit_count;
  logic hit_limit;
  logic hit_gate;
  logic mapped;
  logic wr_ctrl;
  logic wr_limit;
  logic wr_gate;
  logic ctrl_change;
  logic counter_clear;
  logic halted;
  logic match_event;
  ctrl_s wr_fields;

  // clock sources pass two flops before the edge detector
  level_sync #(
    .WIDTH(NUM_SRC)
  ) u_src_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in({internal_ref_clock, external_ref_clock, low_power_osc_clock}),
    .sync_out(src_sync)
  );

  assign src_rise = src_sync & ~src_prev_q;

  always_comb begin
    src_tick = 1'b0;
    if (ctrl_q.src[SRC_IRC_BIT]) begin
      // the internal reference is not kept alive in the deepest stop
      src_tick = src_rise[2] & ~power_mode.deepest_stop_mode;
    end else if (ctrl_q.src == SRC_EXT) begin
      src_tick = src_rise[1];
    end else begin
      src_tick = src_rise[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_q <= '0;
    end else begin
      src_prev_q <= src_sync;
    end
  end

  // apb decode, zero wait states
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign hit_ctrl = (paddr == OFF_STATUS_CONTROL);
  assign hit_count = (paddr == OFF_COUNTER_VALUE);
  assign hit_limit = (paddr == OFF_MATCH_LIMIT);
  assign hit_gate = (paddr == OFF_CLOCK_GATE);
  assign mapped = hit_ctrl | hit_count | hit_limit | hit_gate;
  assign pready = 1'b1;
  assign pslverr = access_phase & ~mapped;

  // with the bus clock gated off the counter registers see no access
  assign wr_ctrl = access_phase & pwrite & hit_ctrl & gate_q;
  assign wr_limit = access_phase & pwrite & hit_limit & gate_q;
  assign wr_gate = access_phase & pwrite & hit_gate;
  assign wr_fields = ctrl_s'(pwdata[7:0]);

  // only a changed value restarts the chain, rewriting the same code is harmless
  assign ctrl_change = wr_ctrl & ((wr_fields.src != ctrl_q.src) |
                                  (wr_fields.ps != ctrl_q.ps));
  assign counter_clear = ctrl_change | wr_limit;

  // debug halt freezes the chain; wait and stop modes do not
  assign halted = power_mode.debug_halt;

  wakeup_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(src_tick),
    .clear(counter_clear),
    .hold(halted),
    .code(ctrl_q.ps),
    .binary_sel(ctrl_q.src[0]),
    .terminal_tick(term_tick)
  );

  assign match_event = term_tick & ~halted & ~counter_clear & (count_q == limit_q);

  // main count
  always_comb begin
    count_d = count_q;
    if (counter_clear) begin
      count_d = COUNT_RST;
    end else if (term_tick && !halted) begin
      if (count_q == limit_q) begin
        count_d = COUNT_RST;
      end else begin
        count_d = count_q + 8'h01;
      end
    end
  end

  // control, limit and gate registers
  always_comb begin
    ctrl_d = ctrl_q;
    limit_d = limit_q;
    gate_d = gate_q;
    if (wr_ctrl) begin
      ctrl_d.src = wr_fields.src;
      ctrl_d.ie = wr_fields.ie;
      ctrl_d.ps = wr_fields.ps;
      if (pwdata[FLAG_BIT]) begin
        ctrl_d.flag = 1'b0;
      end
    end
    // a match in the clearing cycle is kept
    if (match_event) begin
      ctrl_d.flag = 1'b1;
    end
    if (wr_limit) begin
      limit_d = pwdata[7:0];
    end
    if (wr_gate) begin
      gate_d = pwdata[GATE_BIT];
    end
  end

  // read data is captured in the setup cycle
  always_comb begin
    rdata_d = rdata_q;
    if (setup_phase && !pwrite) begin
      rdata_d = '0;
      if (hit_gate) begin
        rdata_d[GATE_BIT] = gate_q;
      end else if (gate_q) begin
        unique case (1'b1)
          hit_ctrl: rdata_d[7:0] = ctrl_q;
          hit_count: rdata_d[7:0] = count_q;
          hit_limit: rdata_d[7:0] = limit_q;
          default: rdata_d = '0;
        endcase
      end
    end
  end

  // only presetn touches these; stop wakeups leave them alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      limit_q <= LIMIT_RST;
      count_q <= COUNT_RST;
      gate_q <= GATE_RST;
      rdata_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      limit_q <= limit_d;
      count_q <= count_d;
      gate_q <= gate_d;
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;

  // request level follows the sticky flag
  assign match_irq = ctrl_q.flag & ctrl_q.ie;
  assign wakeup_req = match_irq & (power_mode.wait_mode |
                                   power_mode.light_stop_mode |
                                   power_mode.deepest_stop_mode);

  // software must enable a source before selecting it; nothing here detects a dead one

endmodule : periodic_wakeup_counter
`default_nettype wire

// ===== verif/periodic_wakeup_counter_chk.sv
`timescale 1ns/10ps
`default_nettype none
module periodic_wakeup_counter_chk
  import periodic_wakeup_counter_pkg::*;
(
  // bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [periodic_wakeup_counter_pkg::ADDR_W-1:0] paddr,
  input wire logic [periodic_wakeup_counter_pkg::DATA_W-1:0] pwdata,
  input wire logic [periodic_wakeup_counter_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // mode and requests
  input wire periodic_wakeup_counter_pkg::power_mode_s power_mode,
  input wire logic match_irq,
  input wire logic wakeup_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr;
  logic mapped;
  logic gate_q;
  logic gate_d;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign mapped = paddr inside {OFF_STATUS_CONTROL, OFF_COUNTER_VALUE, OFF_MATCH_LIMIT,
                                OFF_CLOCK_GATE};
  // gated writes are dropped, so the enable-off check needs the gate state
  always_comb begin
    gate_d = (wr && paddr == OFF_CLOCK_GATE) ? pwdata[GATE_BIT] : gate_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q <= GATE_RST;
    end else begin
      gate_q <= gate_d;
    end
  end
  a_bus_ready: assert property (acc |-> pready)
    else $error("pready low in access");
  a_err_unmapped: assert property (pslverr == (acc && !mapped))
    else $error("pslverr wrong");
  a_read_clean: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0 && (mapped || prdata == 0))
    else $error("read data not clean");
  a_wake_from_irq: assert property (wakeup_req == (match_irq && (power_mode.wait_mode ||
    power_mode.light_stop_mode || power_mode.deepest_stop_mode))) else $error("wakeup wrong");
  a_irq_sticky: assert property (!wr |=> !$fell(match_irq))
    else $error("irq fell without write");
  a_irq_enable_off: assert property (wr && gate_q && paddr == OFF_STATUS_CONTROL &&
    !pwdata[IE_BIT] |=> !match_irq) else $error("irq with enable off");
  a_debug_frozen: assert property (power_mode.debug_halt && !wr |=> !$rose(match_irq))
    else $error("match during debug halt");
  a_reset_quiet: assert property ($rose(presetn) |-> !match_irq && !wakeup_req)
    else $error("requests after reset");
  c_irq: cover property ($rose(match_irq));
  c_wake: cover property ($rose(wakeup_req));
  c_err: cover property (acc && !mapped);
endmodule : periodic_wakeup_counter_chk
bind periodic_wakeup_counter periodic_wakeup_counter_chk chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .power_mode, .match_irq, .wakeup_req);
`default_nettype wire

// ===== verif/periodic_wakeup_counter_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define check(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module periodic_wakeup_counter_tb;
  import periodic_wakeup_counter_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] src_clk = 3'h0;
  power_mode_s power_mode = '0;
  logic match_irq;
  logic wakeup_req;
  logic [7:0] div = 8'h00;
  logic [7:0] rd;
  logic err;
  int miscompares = 0;
  int total_checks = 0;
  periodic_wakeup_counter dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .low_power_osc_clock(src_clk[0]),
    .external_ref_clock(src_clk[1]), .internal_ref_clock(src_clk[2]),
    .power_mode, .match_irq, .wakeup_req);
  always #2 pclk = ~pclk;
  // sources run from time zero, so any selected one is already alive
  always @(posedge pclk) begin
    div <= div + 8'h01;
    src_clk <= {div[2], div[3], div[2]};
  end
  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wait_irq();
    int n;
    n = 0;
    while (match_irq !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    `check(match_irq, 1'b1)
  endtask : wait_irq
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, ADDR_W'(4 * i), 8'h00);
      `check(rd, (i == 3) ? 8'h01 : 8'h00)
    end
    xfer(1'b0, 12'h010, 8'h00);
    `check({err, rd}, 9'h100)
    xfer(1'b1, OFF_MATCH_LIMIT, 8'h03);
    xfer(1'b1, OFF_STATUS_CONTROL, 8'h18);
    wait_irq();
    xfer(1'b0, OFF_COUNTER_VALUE, 8'h00);
    `check(rd, 8'h00)
    xfer(1'b0, OFF_STATUS_CONTROL, 8'h00);
    `check(rd, 8'h98)
    for (int i = 1; i < 4; i++) begin
      @(posedge pclk);
      power_mode <= power_mode_s'(4'h1 << i);
      @(negedge pclk);
      `check(wakeup_req, 1'b1)
    end
    @(posedge pclk);
    power_mode <= '0;
    xfer(1'b1, OFF_STATUS_CONTROL, 8'h98);
    @(negedge pclk);
    `check(match_irq, 1'b0)
    wait_irq();
    xfer(1'b1, OFF_STATUS_CONTROL, 8'h88);
    repeat (100) @(posedge pclk);
    xfer(1'b0, OFF_STATUS_CONTROL, 8'h00);
    `check({match_irq, rd}, 9'h088)
    power_mode <= power_mode_s'(4'h1);
    xfer(1'b1, OFF_MATCH_LIMIT, 8'hff);
    repeat (40) @(posedge pclk);
    xfer(1'b1, OFF_COUNTER_VALUE, 8'h55);
    xfer(1'b0, OFF_COUNTER_VALUE, 8'h00);
    `check(rd, 8'h00)
    power_mode <= '0;
    repeat (40) @(posedge pclk);
    xfer(1'b0, OFF_COUNTER_VALUE, 8'h00);
    `check(rd != 8'h00, 1'b1)
    xfer(1'b1, OFF_STATUS_CONTROL, 8'h0f);
    xfer(1'b0, OFF_COUNTER_VALUE, 8'h00);
    `check(rd, 8'h00)
    xfer(1'b1, OFF_STATUS_CONTROL, 8'h09);
    repeat (40) @(posedge pclk);
    xfer(1'b1, OFF_STATUS_CONTROL, 8'h29);
    xfer(1'b0, OFF_COUNTER_VALUE, 8'h00);
    `check(rd, 8'h00)
    power_mode <= power_mode_s'(4'h2);
    xfer(1'b1, OFF_STATUS_CONTROL, 8'h48);
    repeat (60) @(posedge pclk);
    xfer(1'b0, OFF_COUNTER_VALUE, 8'h00);
    `check(rd, 8'h00)
    power_mode <= power_mode_s'(4'h4);
    repeat (60) @(posedge pclk);
    xfer(1'b0, OFF_COUNTER_VALUE, 8'h00);
    `check(rd != 8'h00, 1'b1)
    power_mode <= '0;
    xfer(1'b1, OFF_CLOCK_GATE, 8'h00);
    xfer(1'b1, OFF_MATCH_LIMIT, 8'h12);
    xfer(1'b0, OFF_STATUS_CONTROL, 8'h00);
    `check(rd, 8'h00)
    xfer(1'b1, OFF_CLOCK_GATE, 8'h01);
    xfer(1'b0, OFF_MATCH_LIMIT, 8'h00);
    `check(rd, 8'hff)
    end_of_test();
  end
endmodule : periodic_wakeup_counter_tb
`default_nettype wire
